/* port_pin_defs.svh */
// constants for the port pin function and strap block
// assumes it is included by its bare name from the package, the design module and the bench
`ifndef PORT_PIN_DEFS_SVH
`define PORT_PIN_DEFS_SVH

// register byte offsets, one aligned word each
`define OFS_PIN_CTRL 8'h00
`define OFS_PRINTER_CTRL 8'h04
`define OFS_MODEM_CTRL 8'h08
`define OFS_HANDSHAKE_STATUS 8'h0C
`define OFS_CONFIG_REG_24 8'h10

// pin control register fields
`define PIN_MODE_LSB 0
`define PIN_MODE_MSB 1
`define PIN_IR_SPEED_BIT 2
`define PIN_IR_FAST_RX_BIT 3

// parallel pin mode codes
`define MODE_PRINTER 2'h0
`define MODE_EXT_SINGLE 2'h1
`define MODE_EXT_DUAL 2'h2

// printer control register fields
`define PRN_LINE_FEED_BIT 0
`define PRN_STROBE_BIT 1
`define PRN_DENSITY_BIT 2

// modem control register fields
`define MDM_REQUEST_SEND_BIT 0
`define MDM_TERMINAL_READY_BIT 1

// handshake status register fields, set bit means the line is asserted
`define HS_CLEAR_TO_SEND_BIT 4
`define HS_SET_READY_BIT 5
`define HS_RING_BIT 6
`define HS_CARRIER_DETECT_BIT 7

// config register 24 fields
`define CONFIG_REG_24_PNP_CLEAR_BIT 0
`define CONFIG_REG_24_CFG_ADDR_BIT 1
`define CONFIG_REG_24_CLOCK_FREQ_BIT 2

// configuration port addresses chosen by the strap
`define CFG_PORT_LOW 8'h2E
`define CFG_PORT_HIGH 8'h4E

// strobe pulse width and clock period
`define STROBE_WIDTH_NS 500
`define CLK_PERIOD_NS 4

// reset value of all software registers
`define REG_RESET 32'h0000_0000

`endif

/* port_pin_pkg.sv */
// types shared by the port pin block
// assumes port_pin_defs.svh sits in the same folder
package port_pin_pkg;
`include "port_pin_defs.svh"

    // strobe pulse sequencer, one-hot
    typedef enum logic [1:0]
    {
        STB_IDLE = 2'b01,
        STB_PULSE = 2'b10
    } strobe_state_t;

endpackage

/* port_pin_mux.sv */
// port pin functions, modem pins and power-on straps behind an AHB-Lite slave
// assumes one AHB-Lite master, word-only transfers, and pins synchronised here
`timescale 1ns/1ps
`include "port_pin_defs.svh"

module port_pin_mux
    import port_pin_pkg::*;
#(
    parameter int STROBE_CYCLES = (`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
    input wire logic clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // parallel port pins, open drain
    output logic printer_line_feed_n_o,
    output logic printer_line_feed_n_oe,
    output logic printer_strobe_n_o,
    output logic printer_strobe_n_oe,
    // uart a modem pins
    input wire logic uart_a_clear_to_send_n,
    input wire logic uart_a_set_ready_n,
    input wire logic uart_a_carrier_detect_n,
    input wire logic uart_a_ring_n,
    input wire logic uart_a_request_send_n_i,
    output logic uart_a_request_send_n_o,
    output logic uart_a_request_send_n_oe,
    input wire logic uart_a_terminal_ready_n_i,
    output logic uart_a_terminal_ready_n_o,
    output logic uart_a_terminal_ready_n_oe,
    input wire logic uart_a_serial_in,
    input wire logic uart_a_serial_out_i,
    output logic uart_a_serial_out_o,
    output logic uart_a_serial_out_oe,
    // infrared pins
    input wire logic infrared_receive,
    output logic infrared_transmit,
    input wire logic infrared_speed_select_i,
    output logic infrared_speed_select_o,
    output logic infrared_speed_select_oe,
    // towards the uart core, same clock
    input wire logic uart_tx_data,
    input wire logic ir_tx_data,
    output logic uart_rx_data,
    output logic ir_rx_data,
    output logic infrared_fast_receive,
    // strap results for the rest of the chip
    output logic [7:0] cfg_port_address,
    output logic pnp_default_clear_n,
    output logic clock_freq_select
);

    // pin synchronisers, stage one feeds only stage two
    logic [9:0] pin_sync1_reg;
    logic [9:0] pin_sync2_reg;
    logic [9:0] pin_raw;
    // ahb data phase bookkeeping
    logic [7:0] addr_reg;
    logic wr_phase_reg;
    logic rd_wait_reg;
    logic [31:0] hrdata_reg;
    // software registers
    logic [31:0] pin_ctrl_reg;
    logic [31:0] printer_ctrl_reg;
    logic [31:0] modem_ctrl_reg;
    logic [2:0] config_reg_24_reg;
    // strap capture
    logic reset_d_reg;
    logic drive_en_reg;
    logic strap_take;
    // strobe sequencer
    strobe_state_t stb_state_reg;
    logic [15:0] stb_count_reg;
    // decoded mode and bus transfer accept
    logic [1:0] mode;
    logic printer_mode;
    logic accept;

    // true when the offset names a mapped register
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // read value of the register at an offset, unmapped reads zero
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (reg_hit(a, `OFS_PIN_CTRL))
            v = pin_ctrl_reg;
        if (reg_hit(a, `OFS_PRINTER_CTRL))
            v = printer_ctrl_reg;
        if (reg_hit(a, `OFS_MODEM_CTRL))
            v = modem_ctrl_reg;
        if (reg_hit(a, `OFS_HANDSHAKE_STATUS))
        begin
            v[`HS_CLEAR_TO_SEND_BIT] = ~pin_sync2_reg[0];
            v[`HS_SET_READY_BIT] = ~pin_sync2_reg[1];
            v[`HS_RING_BIT] = ~pin_sync2_reg[3];
            v[`HS_CARRIER_DETECT_BIT] = ~pin_sync2_reg[2];
        end
        if (reg_hit(a, `OFS_CONFIG_REG_24))
            v = {29'h0000_0000, config_reg_24_reg};
        read_mux = v;
    endfunction

    assign pin_raw = {infrared_speed_select_i, infrared_receive, uart_a_serial_in,
                      uart_a_serial_out_i, uart_a_terminal_ready_n_i,
                      uart_a_request_send_n_i, uart_a_ring_n,
                      uart_a_carrier_detect_n, uart_a_set_ready_n, uart_a_clear_to_send_n};

    // two-stage synchroniser; not reset so straps are sampled while reset is held
    always_ff @(posedge clk)
    begin
        pin_sync1_reg <= pin_raw;
        pin_sync2_reg <= pin_sync1_reg;
    end

    assign mode = pin_ctrl_reg[`PIN_MODE_MSB:`PIN_MODE_LSB];
    assign printer_mode = (mode == `MODE_PRINTER);
    assign accept = hsel & hready & htrans[1];

    // ahb address phase capture; reads take one wait state so data comes from a flop
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            addr_reg <= 8'h00;
            wr_phase_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            if (hready)
            begin
                addr_reg <= haddr[7:0];
                wr_phase_reg <= accept & hwrite;
                rd_wait_reg <= accept & ~hwrite;
            end
            else
            begin
                // wait state over, read data now stands
                rd_wait_reg <= 1'b0;
            end
            if (rd_wait_reg)
                hrdata_reg <= read_mux(addr_reg);
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = ~rd_wait_reg;
    assign hresp = 1'b0;

    // software control registers; writes land in the data phase
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_ctrl_reg <= `REG_RESET;
            printer_ctrl_reg <= `REG_RESET;
            modem_ctrl_reg <= `REG_RESET;
        end
        else if (wr_phase_reg)
        begin
            if (reg_hit(addr_reg, `OFS_PIN_CTRL))
                pin_ctrl_reg <= {28'h000_0000, hwdata[3:0]};
            if (reg_hit(addr_reg, `OFS_PRINTER_CTRL))
                // strobe bit is a trigger and never stored
                printer_ctrl_reg <= {29'h0000_0000, hwdata[`PRN_DENSITY_BIT], 1'b0,
                                     hwdata[`PRN_LINE_FEED_BIT]};
            if (reg_hit(addr_reg, `OFS_MODEM_CTRL))
                modem_ctrl_reg <= {30'h0000_0000, hwdata[1:0]};
        end
    end

    // strap capture on the first edge after reset is released
    always_ff @(posedge clk)
    begin
        reset_d_reg <= reset;
    end
    assign strap_take = reset_d_reg & ~reset;

    // pins with an output enable stay released until straps are taken, so only the pull resistors act
    always_ff @(posedge clk)
    begin
        if (reset)
            drive_en_reg <= 1'b0;
        else if (strap_take)
            drive_en_reg <= 1'b1;
    end

    // config register 24 holding the strap values
    always_ff @(posedge clk)
    begin
        if (reset)
            config_reg_24_reg <= 3'h0;
        else if (strap_take)
        begin
            config_reg_24_reg[`CONFIG_REG_24_PNP_CLEAR_BIT] <= pin_sync2_reg[5];
            config_reg_24_reg[`CONFIG_REG_24_CFG_ADDR_BIT] <= pin_sync2_reg[4];
            config_reg_24_reg[`CONFIG_REG_24_CLOCK_FREQ_BIT] <= pin_sync2_reg[6];
        end
        else if (wr_phase_reg && reg_hit(addr_reg, `OFS_CONFIG_REG_24))
            config_reg_24_reg <= hwdata[2:0];
    end

    assign cfg_port_address = config_reg_24_reg[`CONFIG_REG_24_CFG_ADDR_BIT] ? `CFG_PORT_HIGH : `CFG_PORT_LOW;
    assign pnp_default_clear_n = ~config_reg_24_reg[`CONFIG_REG_24_PNP_CLEAR_BIT];
    assign clock_freq_select = config_reg_24_reg[`CONFIG_REG_24_CLOCK_FREQ_BIT];

    // strobe pulse sequencer; a trigger outside printer mode is dropped
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stb_state_reg <= STB_IDLE;
            stb_count_reg <= 16'h0000;
        end
        else
        begin
            case (stb_state_reg)
                STB_IDLE:
                begin
                    if (wr_phase_reg && reg_hit(addr_reg, `OFS_PRINTER_CTRL) &&
                        hwdata[`PRN_STROBE_BIT] && printer_mode)
                    begin
                        stb_state_reg <= STB_PULSE;
                        stb_count_reg <= 16'(STROBE_CYCLES - 1);
                    end
                end
                STB_PULSE:
                begin
                    // a mode change cuts the pulse short
                    if (stb_count_reg == 16'h0000 || !printer_mode)
                        stb_state_reg <= STB_IDLE;
                    else
                        stb_count_reg <= stb_count_reg - 16'h0001;
                end
                default:
                    stb_state_reg <= STB_IDLE;
            endcase
        end
    end

    // parallel pins, open drain: output always low, enable pulls the line down
    always_comb
    begin
        printer_line_feed_n_o = 1'b0;
        printer_strobe_n_o = 1'b0;
        if (printer_mode)
        begin
            printer_line_feed_n_oe = drive_en_reg & printer_ctrl_reg[`PRN_LINE_FEED_BIT];
            printer_strobe_n_oe = drive_en_reg & (stb_state_reg == STB_PULSE);
        end
        else
        begin
            printer_line_feed_n_oe = drive_en_reg & ~printer_ctrl_reg[`PRN_DENSITY_BIT];
            printer_strobe_n_oe = 1'b0;
        end
    end

    assign uart_a_request_send_n_o = ~modem_ctrl_reg[`MDM_REQUEST_SEND_BIT];
    assign uart_a_terminal_ready_n_o = ~modem_ctrl_reg[`MDM_TERMINAL_READY_BIT];
    assign uart_a_request_send_n_oe = drive_en_reg;
    assign uart_a_terminal_ready_n_oe = drive_en_reg;
    assign uart_a_serial_out_o = uart_tx_data;
    assign uart_a_serial_out_oe = drive_en_reg;
    assign infrared_transmit = ir_tx_data;
    assign uart_rx_data = pin_sync2_reg[7];
    assign ir_rx_data = pin_sync2_reg[8];

    // speed select output or fast receive input
    assign infrared_speed_select_o = pin_ctrl_reg[`PIN_IR_SPEED_BIT];
    assign infrared_speed_select_oe = drive_en_reg & ~pin_ctrl_reg[`PIN_IR_FAST_RX_BIT];
    assign infrared_fast_receive = pin_ctrl_reg[`PIN_IR_FAST_RX_BIT] & pin_sync2_reg[9];

endmodule // port_pin_mux

/* port_pin_mux_assertions.sv */
// checker for the port pin block, watching the top module ports only
// assumes hready is looped back from hreadyout by the bus fabric
`timescale 1ns/1ps
module port_pin_mux_assertions #(
    parameter int STROBE_CYCLES = 125
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic printer_line_feed_n_o,
    input wire logic printer_strobe_n_oe,
    input wire logic uart_a_request_send_n_oe,
    input wire logic infrared_transmit,
    input wire logic ir_tx_data,
    input wire logic [7:0] cfg_port_address
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // cycles the strobe has been pulled so far
    logic [15:0] stb_cnt_reg;
    // counter restarts whenever the strobe lets go
    always_ff @(posedge clk)
    begin
        if (reset || !printer_strobe_n_oe)
            stb_cnt_reg <= 16'h0000;
        else
            stb_cnt_reg <= stb_cnt_reg + 16'h0001;
    end
    sequence rd_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wr_taken;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    a_read_wait: assert property (rd_taken |=> one_wait)
        else $error("read answer not after one wait");
    a_write_nowait: assert property (wr_taken |=> hreadyout)
        else $error("write inserted a wait");
    a_lf_open_drain: assert property (printer_line_feed_n_o == 1'b0)
        else $error("line feed drives high");
    a_strobe_width: assert property ($fell(printer_strobe_n_oe) |->
        stb_cnt_reg == 16'(STROBE_CYCLES))
        else $error("strobe pulse width wrong");
    a_strobe_max: assert property (printer_strobe_n_oe |->
        stb_cnt_reg < 16'(STROBE_CYCLES))
        else $error("strobe pulse held too long");
    a_release_quiet: assert property ($fell(reset) |->
        !printer_strobe_n_oe && !uart_a_request_send_n_oe)
        else $error("pins driven at reset release");
    a_ir_tx_pass: assert property (infrared_transmit == ir_tx_data)
        else $error("infrared transmit does not follow core");
    a_cfg_port_val: assert property ($past(reset) ||
        cfg_port_address == 8'h2E || cfg_port_address == 8'h4E)
        else $error("config port address invalid");
endmodule // port_pin_mux_assertions

bind port_pin_mux port_pin_mux_assertions #(.STROBE_CYCLES(STROBE_CYCLES)) u_chk (
    .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .printer_line_feed_n_o(printer_line_feed_n_o), .printer_strobe_n_oe(printer_strobe_n_oe),
    .uart_a_request_send_n_oe(uart_a_request_send_n_oe),
    .infrared_transmit(infrared_transmit), .ir_tx_data(ir_tx_data),
    .cfg_port_address(cfg_port_address));

/* port_pin_far_side.sv */
// printer, modem and strap resistors seen from the pins
// assumes the bench chooses strap levels and which modem lines are active
`timescale 1ns/1ps
module port_pin_far_side (
    input wire logic [2:0] strap,
    input wire logic [3:0] modem_act,
    input wire logic lf_oe,
    input wire logic stb_oe,
    input wire logic [2:0] drv_o,
    input wire logic [2:0] drv_oe,
    output logic lf_lvl,
    output logic stb_lvl,
    output logic [2:0] drv_lvl,
    output logic [3:0] modem_n
);
    // open drain lines fall back to the internal pull-up
    assign lf_lvl = lf_oe ? 1'b0 : 1'b1;
    assign stb_lvl = stb_oe ? 1'b0 : 1'b1;
    // strap resistors win only while the pin is not driven
    assign drv_lvl = (drv_o & drv_oe) | (strap & ~drv_oe);
    assign modem_n = ~modem_act;
endmodule // port_pin_far_side

/* port_pin_and_straps_bench.sv */
// self-checking bench for the port pin block over AHB-Lite
// assumes the far side model and the bound checker
`timescale 1ns/1ps
`include "port_pin_defs.svh"
module port_pin_function_and_straps_bench;
    import port_pin_pkg::*;
    logic clk = 0, reset = 1, hsel = 0, hwrite = 0, tgl = 0, ir_in = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, strap = 3'h7, drv_o, drv_oe, drv_lvl;
    logic [3:0] modem_act = 4'h0, modem_n;
    logic hreadyout, hresp, lf_o, lf_oe, stb_o, stb_oe, lf_lvl, stb_lvl, irs_o, irs_oe;
    logic fast_rx, freq_sel, pnp_n;
    logic [7:0] cfg_port;
    int num_errors = 0, n_tests = 0, cycles = 0, n;
    initial forever #2 clk = ~clk;
    // free-running activity on the data paths, and the hang guard
    always @(posedge clk)
    begin
        tgl <= ~tgl;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    port_pin_far_side u_port_pin_far_side (.strap(strap), .modem_act(modem_act),
        .lf_oe(lf_oe), .stb_oe(stb_oe), .drv_o(drv_o), .drv_oe(drv_oe),
        .lf_lvl(lf_lvl), .stb_lvl(stb_lvl), .drv_lvl(drv_lvl), .modem_n(modem_n));
    port_pin_mux #(.STROBE_CYCLES(3)) u_port_pin_mux (.clk(clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .printer_line_feed_n_o(lf_o), .printer_line_feed_n_oe(lf_oe),
        .printer_strobe_n_o(stb_o), .printer_strobe_n_oe(stb_oe),
        .uart_a_clear_to_send_n(modem_n[0]), .uart_a_set_ready_n(modem_n[1]),
        .uart_a_carrier_detect_n(modem_n[2]), .uart_a_ring_n(modem_n[3]),
        .uart_a_request_send_n_i(drv_lvl[1]), .uart_a_request_send_n_o(drv_o[1]),
        .uart_a_request_send_n_oe(drv_oe[1]), .uart_a_terminal_ready_n_i(drv_lvl[0]),
        .uart_a_terminal_ready_n_o(drv_o[0]), .uart_a_terminal_ready_n_oe(drv_oe[0]),
        .uart_a_serial_in(tgl), .uart_a_serial_out_i(drv_lvl[2]),
        .uart_a_serial_out_o(drv_o[2]), .uart_a_serial_out_oe(drv_oe[2]),
        .infrared_receive(tgl), .infrared_transmit(), .infrared_speed_select_i(ir_in),
        .infrared_speed_select_o(irs_o), .infrared_speed_select_oe(irs_oe),
        .uart_tx_data(tgl), .ir_tx_data(~tgl), .uart_rx_data(), .ir_rx_data(),
        .infrared_fast_receive(fast_rx), .cfg_port_address(cfg_port),
        .pnp_default_clear_n(pnp_n), .clock_freq_select(freq_sel));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    // one single word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // straps held by the resistors through reset, then driven over
    task automatic t_straps(input logic [2:0] s);
        @(posedge clk);
        reset <= 1'b1; strap <= s;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        settle(3);
        chk(cfg_port, s[1] ? 8'h4E : 8'h2E);
        chk(freq_sel, s[2]);
        chk(pnp_n, !s[0]);
        chk(drv_lvl[2], tgl);
        bus(0, `OFS_CONFIG_REG_24, 0);
        chk(rd[2:0], s);
    endtask
    task automatic t_modem();
        bus(1, `OFS_MODEM_CTRL, 32'h3);
        settle(2);
        chk(drv_lvl[1:0], 2'h0);
        bus(1, `OFS_MODEM_CTRL, 32'h0);
        settle(2);
        chk(drv_lvl[1:0], 2'h3);
        chk(cfg_port, 8'h4E);
    endtask
    // each modem line alone: cts, set-ready, carrier, ring
    task automatic t_status();
        logic [7:0] bitpos [4] = '{8'h10, 8'h20, 8'h80, 8'h40};
        for (int i = 0; i < 4; i++)
        begin
            modem_act <= 4'h1 << i;
            settle(4);
            bus(0, `OFS_HANDSHAKE_STATUS, 0);
            chk(rd[7:0], bitpos[i]);
        end
        modem_act <= 4'h0;
    endtask
    task automatic t_printer();
        bus(1, `OFS_PIN_CTRL, 32'h0);
        bus(1, `OFS_PRINTER_CTRL, 32'h1);
        settle(1);
        chk(lf_lvl, 1'b0);
        bus(1, `OFS_PRINTER_CTRL, 32'h2);
        n = 0;
        #1;
        repeat (12)
        begin
            if (stb_lvl === 1'b0) n++;
            settle(1);
        end
        chk(n, 3);
    endtask
    // both floppy modes: strobe trigger ignored, density on the feed pin
    task automatic t_floppy();
        for (int m = 1; m < 3; m++)
        begin
            bus(1, `OFS_PIN_CTRL, m);
            bus(1, `OFS_PRINTER_CTRL, 32'h6);
            n = 0;
            repeat (8)
            begin
                if (stb_oe !== 1'b0) n++;
                settle(1);
            end
            chk(n, 0);
            chk(lf_lvl, 1'b1);
            bus(1, `OFS_PRINTER_CTRL, 32'h0);
            settle(1);
            chk(lf_lvl, 1'b0);
        end
    endtask
    task automatic t_ir();
        bus(1, `OFS_PIN_CTRL, 32'h4);
        settle(1);
        chk({irs_oe, irs_o}, 2'h3);
        bus(1, `OFS_PIN_CTRL, 32'h8);
        ir_in <= 1'b1;
        settle(4);
        chk({irs_oe, fast_rx}, 2'h1);
        bus(0, 32'h20, 0);
        chk(rd, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        t_straps(3'h7);
        t_modem();
        t_status();
        t_printer();
        t_floppy();
        t_ir();
        t_straps(3'h0);
        tally_and_finish();
    end
endmodule // port_pin_function_and_straps_bench
